// ===== core/rai_defines.svh
`ifndef RAI_DEFINES_SVH
`define RAI_DEFINES_SVH
`define RAI_CLK_MHZ 100
`define RAI_DRAIN_US 5000
`define RAI_BLINK_MS 250
`define RAI_DRAIN_CYC (`RAI_DRAIN_US * `RAI_CLK_MHZ)
`define RAI_BLINK_CYC (`RAI_BLINK_MS * 1000 * `RAI_CLK_MHZ)
`define RAI_OFS_CTRL 3'h0
`define RAI_OFS_FRESP1 3'h1
`define RAI_OFS_FRESP2 3'h2
`define RAI_OFS_STATUS 3'h3
`define RAI_OFS_IRQ_STAT 3'h4
`define RAI_OFS_IRQ_MASK 3'h5
`define RAI_FR1_LATCH 8'hC0
`define RAI_FR1_HICCUP 8'hF8
`define RAI_FR2_LATCH 8'h80
`define RAI_FR2_HICCUP 8'hC0
`define RAI_IRQ_W 5
`define RAI_IRQ_FAULT 0
`define RAI_IRQ_PG 1
`define RAI_IRQ_OTW 2
`define RAI_IRQ_PCAP 3
`define RAI_IRQ_BADSET 4
`endif

// ===== core/rai_pkg.sv
package rai_pkg;
    // operating conditions reported by the power stage
    typedef struct packed {
        logic input_absent;
        logic input_oor;
        logic overvoltage_trip;
        logic overcurrent;
        logic temp_warn;
        logic temp_fault;
        logic power_limited;
    } rai_cond_s;
    typedef struct packed {
        logic green;
        logic red;
    } rai_lamp_s;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_STBY = 4'b0010,
        ST_RUN = 4'b0100,
        ST_DRAIN = 4'b1000
    } rai_state_e;
endpackage

// ===== core/rai_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rai_defines.svh"
module rai_top #(
    parameter int unsigned DRAIN_CYC = `RAI_DRAIN_CYC,
    parameter int unsigned BLINK_CYC = `RAI_BLINK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire rai_pkg::rai_cond_s cond,
    input wire logic input_stby_ok,
    input wire logic remote_onoff_n,
    input wire logic interlock_made,
    input wire logic fault_n_in,
    output logic fault_n_out,
    output logic fault_n_oe,
    input wire logic power_good_n_in,
    output logic power_good_n_out,
    output logic power_good_n_oe,
    input wire logic overtemp_warn_n_in,
    output logic overtemp_warn_n_out,
    output logic overtemp_warn_n_oe,
    input wire logic power_cap_n_in,
    output logic power_cap_n_out,
    output logic power_cap_n_oe,
    output logic module_present_tie,
    output rai_pkg::rai_lamp_s input_ok_lamp,
    output rai_pkg::rai_lamp_s output_state_lamp,
    output logic standby_enable,
    output logic main_enable,
    output logic irq,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************
    // register bus
    // ****************************************
    logic ack_r;
    logic bus_off_r;
    logic [7:0] fresp1_r;
    logic [7:0] fresp2_r;
    logic [`RAI_IRQ_W-1:0] irq_stat_r;
    logic [`RAI_IRQ_W-1:0] irq_mask_r;
    logic [`RAI_IRQ_W-1:0] irq_evt;
    logic [15:0] status_w;
    logic wr_go;
    logic [2:0] widx;
    logic bad_set;
    rai_pkg::rai_state_e state_r;
    logic ovp_latch_r;
    logic tf_latch_r;

    // one wait cycle per access keeps decode and read mux off the bus path
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r & avs_byteenable[0];
    assign widx = avs_address[4:2];

    function automatic logic [31:0] rd_word(input logic [2:0] idx);
        case (idx)
            `RAI_OFS_CTRL: rd_word = {31'h0, bus_off_r};
            `RAI_OFS_FRESP1: rd_word = {24'h0, fresp1_r};
            `RAI_OFS_FRESP2: rd_word = {24'h0, fresp2_r};
            `RAI_OFS_STATUS: rd_word = {16'h0, status_w};
            `RAI_OFS_IRQ_STAT: rd_word = {27'h0, irq_stat_r};
            `RAI_OFS_IRQ_MASK: rd_word = {27'h0, irq_mask_r};
            default: rd_word = 32'h0;
        endcase
    endfunction

    // handshake and read data capture
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_r <= 1'b0;
            avs_readdata <= 32'h0;
        end else if (ce) begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
            if (avs_read & ~ack_r) begin
                avs_readdata <= rd_word(widx);
            end
        end
    end

    // control register: serial-bus off request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_off_r <= 1'b0;
        end else if (ce && wr_go && widx == `RAI_OFS_CTRL) begin
            bus_off_r <= avs_writedata[0];
        end
    end

    // fault-response settings take only their two legal codes
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fresp1_r <= `RAI_FR1_LATCH;
            fresp2_r <= `RAI_FR2_LATCH;
        end else if (ce && wr_go) begin
            if (widx == `RAI_OFS_FRESP1 &&
                (avs_writedata[7:0] == `RAI_FR1_LATCH || avs_writedata[7:0] == `RAI_FR1_HICCUP)) begin
                fresp1_r <= avs_writedata[7:0];
            end
            if (widx == `RAI_OFS_FRESP2 &&
                (avs_writedata[7:0] == `RAI_FR2_LATCH || avs_writedata[7:0] == `RAI_FR2_HICCUP)) begin
                fresp2_r <= avs_writedata[7:0];
            end
        end
    end

    assign bad_set = wr_go &&
        ((widx == `RAI_OFS_FRESP1 && avs_writedata[7:0] != `RAI_FR1_LATCH &&
          avs_writedata[7:0] != `RAI_FR1_HICCUP) ||
         (widx == `RAI_OFS_FRESP2 && avs_writedata[7:0] != `RAI_FR2_LATCH &&
          avs_writedata[7:0] != `RAI_FR2_HICCUP));

    // ****************************************
    // interrupts
    // ****************************************
    // sticky status: a new event beats a write-one clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else if (ce) begin
            if (wr_go && widx == `RAI_OFS_IRQ_MASK) begin
                irq_mask_r <= avs_writedata[`RAI_IRQ_W-1:0];
            end
            if (wr_go && widx == `RAI_OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~avs_writedata[`RAI_IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_r <= irq_stat_r | irq_evt;
            end
        end
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // condition decode and blink timebase
    // ****************************************
    logic remote_off;
    logic hard_off;
    logic [31:0] blink_cnt_r;
    logic blink_r;
    logic [31:0] drain_cnt_r;
    logic run_ok;

    assign remote_off = remote_onoff_n | bus_off_r;
    // protection and lost interlock skip the warning delay
    assign hard_off = cond.overvoltage_trip | cond.temp_fault | ovp_latch_r | tf_latch_r |
                      ~interlock_made | cond.input_oor;
    // run needs the remote pin low; and the interlock made
    assign run_ok = ~remote_off & interlock_made & ~hard_off & ~cond.input_absent;

    // free running half-period toggle shared by all blink states
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (ce) begin
            if (blink_cnt_r >= BLINK_CYC - 1) begin
                blink_cnt_r <= 32'h0;
                blink_r <= ~blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 32'h1;
            end
        end
    end

    // latched protection: hiccup clears when the cause goes, latched waits for remote off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ovp_latch_r <= 1'b0;
            tf_latch_r <= 1'b0;
        end else if (ce) begin
            if (cond.overvoltage_trip) begin
                ovp_latch_r <= (fresp1_r == `RAI_FR1_LATCH);
            end else if (remote_off) begin
                ovp_latch_r <= 1'b0;
            end
            if (cond.temp_fault) begin
                tf_latch_r <= (fresp2_r == `RAI_FR2_LATCH);
            end else if (remote_off) begin
                tf_latch_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // output sequencer
    // ****************************************
    // standby first, main only from standby, standby dropped on low input
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= rai_pkg::ST_OFF;
            drain_cnt_r <= 32'h0;
        end else if (ce) begin
            unique case (state_r)
                rai_pkg::ST_OFF: begin
                    if (input_stby_ok) begin
                        state_r <= rai_pkg::ST_STBY;
                    end
                end
                rai_pkg::ST_STBY: begin
                    if (!input_stby_ok) begin
                        state_r <= rai_pkg::ST_OFF;
                    end else if (run_ok) begin
                        state_r <= rai_pkg::ST_RUN;
                    end
                end
                rai_pkg::ST_RUN: begin
                    drain_cnt_r <= 32'h0;
                    if (!input_stby_ok) begin
                        state_r <= rai_pkg::ST_OFF;
                    end else if (hard_off) begin
                        state_r <= rai_pkg::ST_STBY;
                    end else if (!run_ok) begin
                        state_r <= rai_pkg::ST_DRAIN;
                    end
                end
                rai_pkg::ST_DRAIN: begin
                    drain_cnt_r <= drain_cnt_r + 32'h1;
                    if (!input_stby_ok) begin
                        state_r <= rai_pkg::ST_OFF;
                    end else if (hard_off || drain_cnt_r >= DRAIN_CYC - 1) begin
                        state_r <= rai_pkg::ST_STBY;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // flags, lamps and rails
    // ****************************************
    logic fault_nxt;
    logic pg_low_nxt;
    logic otw_nxt;
    rai_pkg::rai_lamp_s out_lamp_nxt;
    rai_pkg::rai_lamp_s in_lamp_nxt;

    // fault low while a fault is present or its latch is still set
    assign fault_nxt = cond.overvoltage_trip | cond.temp_fault | ovp_latch_r | tf_latch_r;
    assign pg_low_nxt = cond.input_absent | fault_nxt | remote_off |
                        (cond.overcurrent & blink_r) | (state_r == rai_pkg::ST_DRAIN);
    assign otw_nxt = cond.temp_warn | cond.temp_fault;

    always_comb begin
        in_lamp_nxt = '0;
        out_lamp_nxt = '0;
        if (cond.input_oor) begin
            in_lamp_nxt.green = blink_r;
        end else if (!cond.input_absent) begin
            in_lamp_nxt.green = 1'b1;
        end
        if (fault_nxt) begin
            out_lamp_nxt.red = 1'b1;
        end else if (cond.overcurrent) begin
            out_lamp_nxt.green = blink_r;
        end else if (state_r == rai_pkg::ST_RUN) begin
            out_lamp_nxt.green = 1'b1;
        end
    end

    // open drain: data always low, enable pulls
    assign fault_n_out = 1'b0;
    assign power_good_n_out = 1'b0;
    assign overtemp_warn_n_out = 1'b0;
    assign power_cap_n_out = 1'b0;
    assign module_present_tie = 1'b0;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fault_n_oe <= 1'b0;
            power_good_n_oe <= 1'b1;
            overtemp_warn_n_oe <= 1'b0;
            power_cap_n_oe <= 1'b0;
            input_ok_lamp <= '0;
            output_state_lamp <= '0;
            standby_enable <= 1'b0;
            main_enable <= 1'b0;
        end else if (ce) begin
            fault_n_oe <= fault_nxt;
            power_good_n_oe <= pg_low_nxt;
            overtemp_warn_n_oe <= otw_nxt;
            power_cap_n_oe <= cond.power_limited;
            input_ok_lamp <= in_lamp_nxt;
            output_state_lamp <= out_lamp_nxt;
            standby_enable <= (state_r != rai_pkg::ST_OFF) & input_stby_ok;
            main_enable <= (state_r == rai_pkg::ST_RUN || state_r == rai_pkg::ST_DRAIN) &
                           ~hard_off & input_stby_ok;
        end
    end

    // interrupt events on flag assertion edges and on refused fault-response writes
    assign irq_evt[`RAI_IRQ_FAULT] = fault_nxt & ~fault_n_oe;
    assign irq_evt[`RAI_IRQ_PG] = pg_low_nxt & ~power_good_n_oe;
    assign irq_evt[`RAI_IRQ_OTW] = otw_nxt & ~overtemp_warn_n_oe;
    assign irq_evt[`RAI_IRQ_PCAP] = cond.power_limited & ~power_cap_n_oe;
    assign irq_evt[`RAI_IRQ_BADSET] = bad_set;

    // pin levels read back so software sees what the backplane sees
    assign status_w = {tf_latch_r, ovp_latch_r, power_cap_n_in, overtemp_warn_n_in, fault_n_in,
                       power_good_n_in, standby_enable, main_enable, 1'b0, cond};

    // ****************************************
    // assertions
    // ****************************************
    logic [31:0] warn_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (srst || !power_good_n_oe || !main_enable) begin
            warn_cnt_r <= 32'h0;
        end else if (ce) begin
            warn_cnt_r <= warn_cnt_r + 32'h1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_od_flags_low: assert property (fault_n_out == 1'b0 && power_good_n_out == 1'b0)
        else $error("open drain data not low");
    a_ovp_flags: assert property (ce && cond.overvoltage_trip |=> fault_n_oe && power_good_n_oe)
        else $error("overvoltage did not pull fault and power good");
    a_main_remote: assert property (ce && remote_onoff_n && main_enable |=>
        power_good_n_oe || !main_enable)
        else $error("main stayed on without warning after remote release");
    a_drain_time: assert property ($fell(main_enable) && !$past(hard_off) && $past(input_stby_ok)
        |-> $past(warn_cnt_r) >= DRAIN_CYC - 1)
        else $error("main dropped before warning time");
    a_fault_clear: assert property (ce && !fault_nxt ##1 ce |-> ##0 !fault_n_oe)
        else $error("fault flag low without fault");
    a_otw_temp: assert property (ce && cond.temp_warn |=> overtemp_warn_n_oe)
        else $error("warning flag not asserted");
    a_pcap_follow: assert property (ce |=> power_cap_n_oe == $past(cond.power_limited))
        else $error("power limit flag wrong");
    a_present_tie: assert property (module_present_tie == 1'b0)
        else $error("present pin not ground");
    a_interlock_off: assert property (ce && !interlock_made |=> !main_enable)
        else $error("main on without interlock");
    a_stby_before: assert property (main_enable |-> standby_enable)
        else $error("main on without standby");
    a_fr1_legal: assert property (fresp1_r == `RAI_FR1_LATCH || fresp1_r == `RAI_FR1_HICCUP)
        else $error("illegal first fault setting");
    a_fr2_legal: assert property (fresp2_r == `RAI_FR2_LATCH || fresp2_r == `RAI_FR2_HICCUP)
        else $error("illegal second fault setting");
    a_lamp_red_first: assert property (ce && fault_nxt |=> output_state_lamp.red &&
        !output_state_lamp.green)
        else $error("red lamp lost priority");

    c_drain_done: cover property ($fell(main_enable) && $past(state_r) == rai_pkg::ST_DRAIN);
    c_ovp_trip: cover property (main_enable ##1 cond.overvoltage_trip ##1 !main_enable);
    c_bad_write: cover property (bad_set);
    c_irq_up: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== sim/rai_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// backplane controller and pull-up network
// ****************************************
module rai_ctrl_model (
    input wire logic run_req,
    input wire logic seated,
    input wire logic [3:0] flag_oe,
    input wire logic [3:0] flag_out,
    output logic remote_onoff_n,
    output logic interlock_made,
    output logic [3:0] flag_pin
);
    // remote pin held low on request
    // on request the controller shorts the pin to logic ground, otherwise it floats up
    assign remote_onoff_n = run_req ? 1'h0 : 1'h1;
    // interlock contact state
    // contact is only made while the module sits fully in the shelf
    assign interlock_made = seated;
    // open drain resolution
    // pull-ups win unless the device enables its driver, so a released flag reads high
    assign flag_pin = ~flag_oe | flag_out;
endmodule
`default_nettype wire

// ===== sim/tb_rectifier_alarm_indicator.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_rectifier_alarm_indicator;
    localparam int DRAIN = 20;
    localparam int BLINK = 4;
    // flag order {fault, power good, warning, power limit}; lamp 3 means not checked
    localparam logic [6:0] CV [7] = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h04, 7'h02, 7'h01};
    localparam logic [3:0] PV [7] = '{4'hF, 4'hB, 4'hF, 4'h3, 4'hD, 4'h1, 4'hE};
    localparam logic [1:0] OL [7] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
    localparam logic [1:0] IL [7] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2};
    logic sys_clk, srst, ce, input_stby_ok, run_req, seated, remote_onoff_n, interlock_made;
    rai_pkg::rai_cond_s cond;
    logic [3:0] flag_oe, flag_out, flag_pin;
    logic module_present_tie, standby_enable, main_enable, irq, avs_read, avs_write, avs_waitrequest;
    rai_pkg::rai_lamp_s input_ok_lamp, output_state_lamp;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    int mismatches, tests_run, tg, tp;
    logic pl, pp;

    // clock at 100 MHz
    always #5 sys_clk = ~sys_clk;

    rai_top #(.DRAIN_CYC(DRAIN), .BLINK_CYC(BLINK)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .ce(ce), .cond(cond), .input_stby_ok(input_stby_ok),
        .remote_onoff_n(remote_onoff_n), .interlock_made(interlock_made),
        .fault_n_in(flag_pin[3]), .fault_n_out(flag_out[3]), .fault_n_oe(flag_oe[3]),
        .power_good_n_in(flag_pin[2]), .power_good_n_out(flag_out[2]), .power_good_n_oe(flag_oe[2]),
        .overtemp_warn_n_in(flag_pin[1]), .overtemp_warn_n_out(flag_out[1]),
        .overtemp_warn_n_oe(flag_oe[1]), .power_cap_n_in(flag_pin[0]), .power_cap_n_out(flag_out[0]),
        .power_cap_n_oe(flag_oe[0]), .module_present_tie(module_present_tie),
        .input_ok_lamp(input_ok_lamp), .output_state_lamp(output_state_lamp),
        .standby_enable(standby_enable), .main_enable(main_enable), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    rai_ctrl_model i_ctrl (
        .run_req(run_req), .seated(seated), .flag_oe(flag_oe), .flag_out(flag_out),
        .remote_onoff_n(remote_onoff_n), .interlock_made(interlock_made), .flag_pin(flag_pin)
    );

    // ************
    // bench tasks
    // ************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // one bus access; waitrequest and read data are settled at the negedge before the taking edge
    // no cycle limit here: only the watchdog ends a wait for the answer
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
        logic ok;
        ok = 1'h0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        while (!ok) begin
            @(negedge sys_clk);
            ok = (avs_waitrequest === 1'h0);
            rd = avs_readdata;
            @(posedge sys_clk);
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask

    task automatic wait_main();
        for (int n = 0; n < 200 && main_enable !== 1'h1; n++) @(negedge sys_clk);
        `CHK("main_enable", 1'h1, main_enable)
    endtask

    // latched faults only clear through a remote off with the cause gone
    task automatic recover();
        @(posedge sys_clk);
        cond <= '0;
        run_req <= 1'h0;
        cyc(DRAIN + 6);
        @(posedge sys_clk);
        run_req <= 1'h1;
        wait_main();
    endtask

    // *********
    // watchdog
    // *********
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end

    // **************
    // main sequence
    // **************
    initial begin
        sys_clk = 1'h0; srst = 1'h1; ce = 1'h1; cond = '0; input_stby_ok = 1'h1; run_req = 1'h1;
        seated = 1'h1; avs_address = 5'h00; avs_read = 1'h0; avs_write = 1'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'hF; mismatches = 0; tests_run = 0; rd = 32'h0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'h0;
        cyc(1);
        `CHK("flags at reset", 4'hB, flag_pin)
        `CHK("module present", 1'h0, module_present_tie)
        `CHK("irq at reset", 1'h0, irq)
        for (int n = 0; n < 50 && standby_enable !== 1'h1; n++) @(negedge sys_clk);
        `CHK("standby first", 2'h2, {standby_enable, main_enable})
        wait_main();
        `CHK("normal lamps", 4'hA, {input_ok_lamp, output_state_lamp})
        // condition table, each followed by a full recovery
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            cond <= rai_pkg::rai_cond_s'(CV[i]);
            cyc(3);
            `CHK("flag pins", PV[i], flag_pin)
            `CHK("output lamp", OL[i], output_state_lamp)
            if (IL[i] != 2'h3) `CHK("input lamp", IL[i], input_ok_lamp)
            if (CV[i] == 7'h10 || CV[i] == 7'h02) `CHK("protect drop", 1'h0, main_enable)
            recover();
        end
        // overcurrent: lamp blinks and power good pulses
        @(posedge sys_clk);
        cond <= rai_pkg::rai_cond_s'(7'h08);
        cyc(3);
        tg = 0; tp = 0; pl = output_state_lamp.green; pp = flag_pin[2];
        repeat (16) begin
            cyc(1);
            if (output_state_lamp.green !== pl) tg++;
            if (flag_pin[2] !== pp) tp++;
            pl = output_state_lamp.green;
            pp = flag_pin[2];
            `CHK("blink red off", 1'h0, output_state_lamp.red)
        end
        `CHK("lamp blink period", 1'h1, tg >= 3 && tg <= 4)
        `CHK("pg pulse period", 1'h1, tp >= 3 && tp <= 4)
        recover();
        // remote release: power good warns a full drain time ahead
        @(posedge sys_clk);
        run_req <= 1'h0;
        cyc(3);
        `CHK("pg early", 2'h1, {flag_pin[2], main_enable})
        cyc(DRAIN - 2);
        `CHK("main held", 1'h1, main_enable)
        cyc(6);
        `CHK("main off", 1'h0, main_enable)
        `CHK("remote lamp", 4'h8, {input_ok_lamp, output_state_lamp})
        @(posedge sys_clk);
        run_req <= 1'h1;
        wait_main();
        // a write without the low byte lane must leave the control bit alone
        @(posedge sys_clk);
        avs_byteenable <= 4'hE;
        bus(1'h1, 3'h0, 32'h1);
        cyc(3);
        `CHK("byte lane off", 2'h3, {flag_pin[2], main_enable})
        @(posedge sys_clk);
        avs_byteenable <= 4'hF;
        // serial-bus off through control bit 0 behaves the same
        bus(1'h1, 3'h0, 32'h1);
        cyc(3);
        `CHK("bus off pg", 1'h0, flag_pin[2])
        cyc(DRAIN + 4);
        `CHK("bus off main", 1'h0, main_enable)
        bus(1'h1, 3'h0, 32'h0);
        wait_main();
        // interlock opened mid run
        @(posedge sys_clk);
        seated <= 1'h0;
        cyc(3);
        `CHK("interlock open", 1'h0, main_enable)
        @(posedge sys_clk);
        seated <= 1'h1;
        wait_main();
        // fault-response settings, interrupt and unmapped place
        bus(1'h0, 3'h1, 32'h0);
        `CHK("fresp1 reset", 32'hC0, rd)
        bus(1'h0, 3'h2, 32'h0);
        `CHK("fresp2 reset", 32'h80, rd)
        bus(1'h1, 3'h5, 32'h0);
        bus(1'h1, 3'h4, 32'h1F);
        bus(1'h1, 3'h1, 32'h55);
        bus(1'h0, 3'h1, 32'h0);
        `CHK("fresp1 refused", 32'hC0, rd)
        `CHK("irq masked", 1'h0, irq)
        bus(1'h1, 3'h1, 32'hF8);
        bus(1'h0, 3'h1, 32'h0);
        `CHK("fresp1 hiccup", 32'hF8, rd)
        bus(1'h1, 3'h2, 32'hC0);
        bus(1'h1, 3'h2, 32'hF8);
        bus(1'h0, 3'h2, 32'h0);
        `CHK("fresp2 hiccup", 32'hC0, rd)
        bus(1'h0, 3'h4, 32'h0);
        `CHK("bad setting bit", 32'h10, rd & 32'h10)
        bus(1'h1, 3'h5, 32'h10);
        cyc(1);
        `CHK("irq raised", 1'h1, irq)
        bus(1'h1, 3'h4, 32'h10);
        cyc(1);
        `CHK("irq cleared", 1'h0, irq)
        bus(1'h1, 3'h6, 32'hFF);
        bus(1'h0, 3'h6, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        bus(1'h0, 3'h3, 32'h0);
        `CHK("status rails", 32'h3F00, rd & 32'hFFFF)
        // clock enable low freezes the rails even though the input drops
        @(posedge sys_clk);
        ce <= 1'h0;
        input_stby_ok <= 1'h0;
        cyc(4);
        `CHK("ce freeze", 2'h3, {standby_enable, main_enable})
        // input too low for standby drops both rails once the clock runs again
        @(posedge sys_clk);
        ce <= 1'h1;
        cyc(4);
        `CHK("rails off", 2'h0, {standby_enable, main_enable})
        print_verdict();
    end
endmodule
`default_nettype wire
